/* File: src/pmr_regs.sv */
/*
  AHB-Lite slave holding the peripheral power control, reset source,
  wake source, async wake enable, options and revision registers.
  Assumes the reset controller and wake logic present their cause vectors
  as synchronous levels on clk, the reset cause stable from reset release onward.
  The reset source vector is sampled once, on the first edge after release;
  a cause that appears later is not recorded until the next reset.
*/
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/100ps
`include "pmr_consts.svh"

module pmr_regs
  import pmr_pkg::*;
#(
  parameter logic [11:0] REVISION = 12'h100, // Arbitrary value
  parameter logic [31:0] OPTIONS = `PMR_OPT_RESET
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [31:0] resetCause,
  input wire logic [31:0] wakeCause,
  output logic timerRequestClockGate,
  output logic twoWireSlaveRequestClockGate,
  output logic resetPinTestMode,
  output logic resetPullupOff,
  output logic usbControllerWake,
  output logic twoWireSlaveWake
);

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  logic wrPend_q, wrPend_d;
  logic rdPend_q, rdPend_d;
  pmr_off_t addr_q, addr_d;
  logic take;

  assign take = hsel && hready && htrans[1];

  always_comb begin
    wrPend_d = take && hwrite;
    rdPend_d = take && !hwrite;
    addr_d = take ? pmr_off_t'({haddr[11:2], 2'b00}) : addr_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wrPend_q <= wrPend_d;
      rdPend_q <= rdPend_d;
      addr_q <= addr_d;
    end
  end

  // ----------------------------------------------------------------
  // Writable registers and cause capture
  // ----------------------------------------------------------------
  pmr_word_t ppc_q, ppc_d;
  pmr_word_t awe_q, awe_d;
  pmr_word_t rsf_q, rsf_d;
  pmr_word_t wsf_q, wsf_d;
  logic seen_q, seen_d;

  always_comb begin
    ppc_d = ppc_q;
    awe_d = awe_q;
    // Only the two writable offsets decode; all others drop the data
    if (wrPend_q && addr_q == `PMR_OFF_PPC) begin
      ppc_d = hwdata & `PMR_PPC_MASK;
    end
    if (wrPend_q && addr_q == `PMR_OFF_AWE) begin
      awe_d = hwdata & `PMR_AWE_MASK;
    end
    // Reset causes are caught on the first edge after release, not in reset; wake causes on every edge
    seen_d = 1'b1;
    rsf_d = seen_q ? rsf_q : (resetCause & `PMR_RSF_MASK);
    wsf_d = wakeCause & `PMR_WSF_MASK;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ppc_q <= `PMR_PPC_RESET;
      awe_q <= `PMR_AWE_RESET;
      rsf_q <= 32'h00000000;
      wsf_q <= 32'h00000000;
      seen_q <= 1'b0;
    end else begin
      ppc_q <= ppc_d;
      awe_q <= awe_d;
      rsf_q <= rsf_d;
      wsf_q <= wsf_d;
      seen_q <= seen_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data and outputs
  // ----------------------------------------------------------------
  pmr_word_t rdata_q, rdata_d;

  always_comb begin
    rdata_d = 32'h00000000;
    if (take && !hwrite) begin
      case (pmr_off_t'({haddr[11:2], 2'b00}))
        `PMR_OFF_PPC: rdata_d = ppc_q;
        `PMR_OFF_RSF: rdata_d = rsf_q;
        `PMR_OFF_WSF: rdata_d = wsf_q;
        `PMR_OFF_AWE: rdata_d = awe_q;
        `PMR_OFF_OPT: rdata_d = OPTIONS & `PMR_OPT_MASK;
        `PMR_OFF_REV: rdata_d = {20'h00000, REVISION};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign timerRequestClockGate = ppc_q[`PMR_PPC_TIMER_CLK];
  assign twoWireSlaveRequestClockGate = ppc_q[`PMR_PPC_TWO_WIRE_SLAVE_WAKE_CLK];
  assign resetPinTestMode = ppc_q[`PMR_PPC_TEST_MODE];
  assign resetPullupOff = ppc_q[`PMR_PPC_PULLUP_OFF];
  assign usbControllerWake = awe_q[0];
  assign twoWireSlaveWake = awe_q[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ppc_write_lands: assert property (
    take && hwrite && haddr[11:0] == `PMR_OFF_PPC ##1 1'b1
    |=> timerRequestClockGate == $past(hwdata[4]))
    else $error("control write did not reach timer clock gate");
  a_two_wire_slave_wake_write_lands: assert property (
    take && hwrite && haddr[11:0] == `PMR_OFF_PPC ##1 1'b1
    |=> twoWireSlaveRequestClockGate == $past(hwdata[3]))
    else $error("control write did not reach two-wire clock gate");
  a_pullup_write_lands: assert property (
    take && hwrite && haddr[11:0] == `PMR_OFF_PPC ##1 1'b1
    |=> resetPullupOff == $past(hwdata[0]))
    else $error("control write did not reach pull-up control");
  a_test_write_lands: assert property (
    take && hwrite && haddr[11:0] == `PMR_OFF_PPC ##1 1'b1
    |=> resetPinTestMode == $past(hwdata[2]))
    else $error("control write did not reach test mode");
  a_ppc_reserved_zero: assert property (
    (ppc_q & ~`PMR_PPC_MASK) == 32'h00000000)
    else $error("reserved control bits set");
  a_cause_stable: assert property (
    seen_q |=> $stable(rsf_q))
    else $error("reset source changed after capture");
  a_awe_write_lands: assert property (
    take && hwrite && haddr[11:0] == `PMR_OFF_AWE ##1 1'b1
    |=> {twoWireSlaveWake, usbControllerWake} == $past(hwdata[1:0]))
    else $error("wake enable write lost");
  a_rev_read: assert property (
    take && !hwrite && haddr[11:0] == `PMR_OFF_REV |=> hrdata == {20'h00000, REVISION})
    else $error("revision read wrong");
  a_opt_read: assert property (
    take && !hwrite && haddr[11:0] == `PMR_OFF_OPT |=> hrdata == (OPTIONS & `PMR_OPT_MASK))
    else $error("options read wrong");
  a_ro_write_ignored: assert property (
    take && hwrite && haddr[11:0] != `PMR_OFF_PPC && haddr[11:0] != `PMR_OFF_AWE
    |=> ##1 $stable(ppc_q) && $stable(awe_q))
    else $error("write to other offset changed a register");

  // ----------------------------------------------------------------
  // Reset values, checked while reset is held
  // ----------------------------------------------------------------
  // These run with reset active, so the default disable is switched off
  a_ppc_reset_value: assert property (
    disable iff (1'b0) !rst_n |-> ppc_q == `PMR_PPC_RESET)
    else $error("control register not at reset value");
  a_gates_reset_value: assert property (
    disable iff (1'b0) !rst_n
    |-> timerRequestClockGate && twoWireSlaveRequestClockGate)
    else $error("request clocks not enabled in reset");
  a_pins_reset_value: assert property (
    disable iff (1'b0) !rst_n |-> !resetPinTestMode && !resetPullupOff)
    else $error("reset pin controls wrong in reset");
  a_awe_reset_value: assert property (
    disable iff (1'b0) !rst_n |-> awe_q == `PMR_AWE_RESET)
    else $error("wake enables not cleared in reset");
  a_rdata_reset_value: assert property (
    disable iff (1'b0) !rst_n |-> hrdata == 32'h00000000)
    else $error("read data not idle in reset");

  // ----------------------------------------------------------------
  // Reset source capture, one check per flag
  // ----------------------------------------------------------------
  // Each flag must match the cause level present on the capture edge
  a_por_flag_caught: assert property (
    $rose(seen_q)
    |-> rsf_q[`PMR_RSF_POWER_ON] == $past(resetCause[`PMR_RSF_POWER_ON]))
    else $error("power-on flag not captured");
  a_bod_flag_caught: assert property (
    $rose(seen_q)
    |-> rsf_q[`PMR_RSF_BROWN_OUT] == $past(resetCause[`PMR_RSF_BROWN_OUT]))
    else $error("brown-out flag not captured");
  a_pin_flag_caught: assert property (
    $rose(seen_q)
    |-> rsf_q[`PMR_RSF_PIN] == $past(resetCause[`PMR_RSF_PIN]))
    else $error("reset pin flag not captured");
  a_wdog_flag_caught: assert property (
    $rose(seen_q)
    |-> rsf_q[`PMR_RSF_WATCHDOG] == $past(resetCause[`PMR_RSF_WATCHDOG]))
    else $error("watchdog flag not captured");
  a_jtag_flag_caught: assert property (
    $rose(seen_q)
    |-> rsf_q[`PMR_RSF_JTAG] == $past(resetCause[`PMR_RSF_JTAG]))
    else $error("jtag flag not captured");
  a_sleep_flag_caught: assert property (
    $rose(seen_q)
    |-> rsf_q[`PMR_RSF_SLEEP] == $past(resetCause[`PMR_RSF_SLEEP]))
    else $error("sleep flag not captured");
  a_illegal_flag_caught: assert property (
    $rose(seen_q)
    |-> rsf_q[`PMR_RSF_ILLEGAL] == $past(resetCause[`PMR_RSF_ILLEGAL]))
    else $error("illegal access flag not captured");
  a_strobe_flag_caught: assert property (
    $rose(seen_q)
    |-> rsf_q[`PMR_RSF_DEBUG_STROBE] == $past(resetCause[`PMR_RSF_DEBUG_STROBE]))
    else $error("debug strobe flag not captured");
  a_onepin_flag_caught: assert property (
    $rose(seen_q)
    |-> rsf_q[`PMR_RSF_ONE_PIN_DEBUG] == $past(resetCause[`PMR_RSF_ONE_PIN_DEBUG]))
    else $error("single-pin debug flag not captured");
  a_rsf_read: assert property (
    take && !hwrite && haddr[11:0] == `PMR_OFF_RSF |=> hrdata == $past(rsf_q))
    else $error("reset source read wrong");
  a_rsf_reserved_zero: assert property (
    (rsf_q & ~`PMR_RSF_MASK) == 32'h00000000)
    else $error("reserved reset source bits set");
  a_rsf_write_ignored: assert property (
    take && hwrite && haddr[11:0] == `PMR_OFF_RSF
    |=> ##1 $stable(rsf_q))
    else $error("write changed reset source");

  // ----------------------------------------------------------------
  // Wake source mirror and enables
  // ----------------------------------------------------------------
  // The mirror lags its input by one edge, so the capture edge is skipped
  a_usb_wake_flag: assert property (
    seen_q |-> wsf_q[`PMR_WSF_USB] == $past(wakeCause[`PMR_WSF_USB]))
    else $error("usb wake flag lost");
  a_two_wire_slave_wake_wake_flag: assert property (
    seen_q |-> wsf_q[`PMR_WSF_TWO_WIRE] == $past(wakeCause[`PMR_WSF_TWO_WIRE]))
    else $error("two-wire wake flag lost");
  a_eirq_wake_flag: assert property (
    seen_q |-> wsf_q[`PMR_WSF_EXT_IRQ] == $past(wakeCause[`PMR_WSF_EXT_IRQ]))
    else $error("external irq wake flag lost");
  a_timer_wake_flag: assert property (
    seen_q |-> wsf_q[`PMR_WSF_TIMER] == $past(wakeCause[`PMR_WSF_TIMER]))
    else $error("timer wake flag lost");
  a_wsf_reserved_zero: assert property (
    (wsf_q & ~`PMR_WSF_MASK) == 32'h00000000)
    else $error("reserved wake source bits set");
  a_wsf_read: assert property (
    take && !hwrite && haddr[11:0] == `PMR_OFF_WSF |=> hrdata == $past(wsf_q))
    else $error("wake source read wrong");
  a_wsf_write_ignored: assert property (
    take && hwrite && haddr[11:0] == `PMR_OFF_WSF
    |=> ##1 wsf_q == ($past(wakeCause) & `PMR_WSF_MASK))
    else $error("write changed wake source");
  a_awe_reserved_zero: assert property (
    (awe_q & ~`PMR_AWE_MASK) == 32'h00000000)
    else $error("reserved wake enable bits set");
  a_awe_read: assert property (
    take && !hwrite && haddr[11:0] == `PMR_OFF_AWE |=> hrdata == $past(awe_q))
    else $error("wake enable read wrong");
  a_usb_enable_bit: assert property (
    usbControllerWake == awe_q[`PMR_AWE_USB])
    else $error("usb wake enable output wrong");
  a_two_wire_slave_wake_enable_bit: assert property (
    twoWireSlaveWake == awe_q[`PMR_AWE_TWO_WIRE])
    else $error("two-wire wake enable output wrong");

  // ----------------------------------------------------------------
  // Options and revision fields
  // ----------------------------------------------------------------
  // Each option bit is checked alone so a swapped field shows by name
  a_bridge_a_read: assert property (
    take && !hwrite && haddr[11:0] == `PMR_OFF_OPT
    |=> hrdata[`PMR_OPT_BRIDGE_A] == OPTIONS[`PMR_OPT_BRIDGE_A])
    else $error("bridge a option wrong");
  a_bridge_b_read: assert property (
    take && !hwrite && haddr[11:0] == `PMR_OFF_OPT
    |=> hrdata[`PMR_OPT_BRIDGE_B] == OPTIONS[`PMR_OPT_BRIDGE_B])
    else $error("bridge b option wrong");
  a_bridge_c_read: assert property (
    take && !hwrite && haddr[11:0] == `PMR_OFF_OPT
    |=> hrdata[`PMR_OPT_BRIDGE_C] == OPTIONS[`PMR_OPT_BRIDGE_C])
    else $error("bridge c option wrong");
  a_bridge_d_read: assert property (
    take && !hwrite && haddr[11:0] == `PMR_OFF_OPT
    |=> hrdata[`PMR_OPT_BRIDGE_D] == OPTIONS[`PMR_OPT_BRIDGE_D])
    else $error("bridge d option wrong");
  a_overclock_read: assert property (
    take && !hwrite && haddr[11:0] == `PMR_OFF_OPT
    |=> hrdata[`PMR_OPT_OVERCLOCK] == OPTIONS[`PMR_OPT_OVERCLOCK])
    else $error("overclock guard option wrong");
  a_fast_clk_read: assert property (
    take && !hwrite && haddr[11:0] == `PMR_OFF_OPT
    |=> hrdata[`PMR_OPT_FAST_CLK] == OPTIONS[`PMR_OPT_FAST_CLK])
    else $error("fast bus event clock option wrong");
  a_opt_reserved_zero: assert property (
    take && !hwrite && haddr[11:0] == `PMR_OFF_OPT
    |=> (hrdata & ~`PMR_OPT_MASK) == 32'h00000000)
    else $error("reserved option bits set");
  a_rev_high_zero: assert property (
    take && !hwrite && haddr[11:0] == `PMR_OFF_REV
    |=> hrdata[31:12] == 20'h00000)
    else $error("revision variant bits set");

  // ----------------------------------------------------------------
  // Bus behaviour
  // ----------------------------------------------------------------
  // Zero wait states: every data phase ends on the next edge
  a_ready_always: assert property (
    hreadyout == 1'b1)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (
    hresp == 1'b0)
    else $error("slave answered with an error");
  a_read_idle_zero: assert property (
    !(take && !hwrite)
    |=> hrdata == 32'h00000000)
    else $error("read data not idle outside a read");
  a_ppc_read: assert property (
    take && !hwrite && haddr[11:0] == `PMR_OFF_PPC
    |=> hrdata == $past(ppc_q))
    else $error("control read wrong");
  a_unmapped_read_zero: assert property (
    take && !hwrite && haddr[11:0] != `PMR_OFF_PPC && haddr[11:0] != `PMR_OFF_RSF
    && haddr[11:0] != `PMR_OFF_WSF && haddr[11:0] != `PMR_OFF_AWE
    && haddr[11:0] != `PMR_OFF_OPT && haddr[11:0] != `PMR_OFF_REV
    |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_ppc_hold_no_write: assert property (
    !wrPend_q |=> $stable(ppc_q))
    else $error("control changed without a write");
  a_awe_hold_no_write: assert property (
    !wrPend_q |=> $stable(awe_q))
    else $error("wake enables changed without a write");

  c_ppc_write: cover property (take && hwrite && haddr[11:0] == `PMR_OFF_PPC);
  c_rsf_read: cover property (take && !hwrite && haddr[11:0] == `PMR_OFF_RSF);
  c_awe_write: cover property (take && hwrite && haddr[11:0] == `PMR_OFF_AWE);
  c_wsf_read: cover property (take && !hwrite && haddr[11:0] == `PMR_OFF_WSF);
  c_rev_read: cover property (take && !hwrite && haddr[11:0] == `PMR_OFF_REV);

endmodule

/* File: src/pmr_consts.svh */
/*
  Constants for the power manager cause and configuration register slice:
  byte offsets, field positions, reset values and bus encodings.
  Assumes it is included once per compile unit by the module; the package does not include it.
*/
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH

`define PMR_OFF_PPC 12'h160
`define PMR_OFF_RSF 12'h180
`define PMR_OFF_WSF 12'h184
`define PMR_OFF_AWE 12'h188
`define PMR_OFF_OPT 12'h3f8
`define PMR_OFF_REV 12'h3fc

`define PMR_PPC_PULLUP_OFF 0
`define PMR_PPC_TEST_MODE 2
`define PMR_PPC_TWO_WIRE_SLAVE_WAKE_CLK 3
`define PMR_PPC_TIMER_CLK 4
`define PMR_PPC_RESET 32'h00000018
`define PMR_PPC_MASK 32'h0000001d

`define PMR_RSF_MASK 32'h000009df
`define PMR_WSF_MASK 32'h00030003
`define PMR_AWE_RESET 32'h00000000
`define PMR_AWE_MASK 32'h00000003
`define PMR_OPT_RESET 32'h00000003
`define PMR_OPT_MASK 32'h000000cf
`define PMR_REV_MASK 32'h00000fff

`define PMR_RSF_POWER_ON 0
`define PMR_RSF_BROWN_OUT 1
`define PMR_RSF_PIN 2
`define PMR_RSF_WATCHDOG 3
`define PMR_RSF_JTAG 4
`define PMR_RSF_SLEEP 6
`define PMR_RSF_ILLEGAL 7
`define PMR_RSF_DEBUG_STROBE 8
`define PMR_RSF_ONE_PIN_DEBUG 11
`define PMR_WSF_USB 0
`define PMR_WSF_TWO_WIRE 1
`define PMR_WSF_EXT_IRQ 16
`define PMR_WSF_TIMER 17
`define PMR_AWE_USB 0
`define PMR_AWE_TWO_WIRE 1
`define PMR_OPT_BRIDGE_A 0
`define PMR_OPT_BRIDGE_B 1
`define PMR_OPT_BRIDGE_C 2
`define PMR_OPT_BRIDGE_D 3
`define PMR_OPT_OVERCLOCK 6
`define PMR_OPT_FAST_CLK 7

`define PMR_HTRANS_NONSEQ 2'h2
`define PMR_HTRANS_SEQ 2'h3
`define PMR_HSIZE_WORD 3'h2

`endif

/* File: src/pmr_pkg.sv */
/*
  Types for the power manager register slice.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pmr_pkg;
  typedef logic [31:0] pmr_word_t;
  typedef logic [11:0] pmr_off_t;
endpackage

/* File: verification/pmr_regs_tb.sv */
/*
  Self-checking bench for the power manager register slice: AHB-Lite tasks
  and directed register sequences.
  Assumes pmr_pkg and pmr_regs are compiled first.
*/
`timescale 1ns/100ps
module testbench;
  import pmr_pkg::*;
  localparam logic [11:0] REV = 12'h2a5; // Arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] resetCause = 32'h0;
  logic [31:0] wakeCause = 32'h0;
  wire [5:0] outsSeen;
  int errTotal = 0;
  int cmpCount = 0;
  int causeBits[9] = '{0, 1, 2, 3, 4, 6, 7, 8, 11};
  int wakeBits[4] = '{0, 1, 16, 17};
  pmr_word_t vals[6] = '{32'h0, 32'h1, 32'h4, 32'h8, 32'hffffffff, 32'h18};

  assign hready = hreadyout;

  pmr_regs #(.REVISION(REV)) uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .resetCause(resetCause),
    .wakeCause(wakeCause), .timerRequestClockGate(outsSeen[5]),
    .twoWireSlaveRequestClockGate(outsSeen[4]), .resetPinTestMode(outsSeen[3]),
    .resetPullupOff(outsSeen[2]), .usbControllerWake(outsSeen[1]),
    .twoWireSlaveWake(outsSeen[0]));

  always #4 clk = ~clk;

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string name, input pmr_word_t exp, input pmr_word_t got);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Called right after a rising edge; returns at the data-phase edge
  task automatic xfer(input pmr_word_t a, input logic w, input pmr_word_t d,
      output pmr_word_t r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask

  task automatic wr(input pmr_word_t a, input pmr_word_t d);
    pmr_word_t r;
    xfer(a, 1'b1, d, r);
  endtask

  task automatic rd(input pmr_word_t a, input pmr_word_t e, input string name);
    pmr_word_t r;
    xfer(a, 1'b0, 32'h0, r);
    chk(name, e, r);
  endtask

  // Outputs update on the data-phase edge itself, so look mid-cycle after it
  task automatic outs(input logic [5:0] e);
    @(negedge clk);
    chk("control outputs", {26'h0, e}, {26'h0, outsSeen});
    @(posedge clk);
  endtask

  task automatic doReset(input pmr_word_t cause);
    resetCause <= cause;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Directed sequence
  // ----------------------------------------
  initial begin
    doReset(32'hffffffff);
    outs(6'b110000);
    rd(32'h160, 32'h18, "control");
    rd(32'h188, 32'h0, "wake enables");
    rd(32'h3f8, 32'h3, "options");
    rd(32'h3fc, {20'h0, REV}, "revision");
    rd(32'h180, 32'h9df, "reset source");
    rd(32'h200, 32'h0, "unmapped");
    foreach (vals[i]) begin
      wr(32'h160, vals[i]);
      outs({vals[i][4], vals[i][3], vals[i][2], vals[i][0], 2'b00});
      rd(32'h160, vals[i] & 32'h1d, "control");
    end
    foreach (vals[i]) begin
      wr(32'h188, vals[i]);
      outs({4'b1100, vals[i][0], vals[i][1]});
      rd(32'h188, vals[i] & 32'h3, "wake enables");
    end
    wakeCause <= 32'hffffffff;
    @(posedge clk);
    rd(32'h184, 32'h30003, "wake source");
    wr(32'h180, 32'h0);
    wr(32'h184, 32'h0);
    wr(32'h3f8, 32'h0);
    wr(32'h3fc, 32'h0);
    rd(32'h180, 32'h9df, "reset source");
    rd(32'h184, 32'h30003, "wake source");
    rd(32'h3f8, 32'h3, "options");
    rd(32'h3fc, {20'h0, REV}, "revision");
    foreach (wakeBits[i]) begin
      wakeCause <= 32'h1 << wakeBits[i];
      @(posedge clk);
      rd(32'h184, 32'h1 << wakeBits[i], "wake source");
    end
    foreach (causeBits[i]) begin
      doReset(32'h1 << causeBits[i]);
      outs(6'b110000);
      rd(32'h180, 32'h1 << causeBits[i], "reset source");
    end
    resetCause <= 32'h0;
    rd(32'h180, 32'h800, "reset source held");
    end_of_test();
  end

  initial begin
    #(8 * 20000);
    errTotal++;
    end_of_test();
  end
endmodule
